/* rtl/fdv_pkg.sv */
/*
 * Shared constants of the frequency divider: setting widths, defaults and limits,
 * the counter's rising point and the state encoding.
 * Assumes nothing of its surroundings; it is compiled before every design file.
 */
package fdv_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int SET_W = 16;
    localparam int CNT_W = SET_W + 2;

    // ************************************************************
    // Setting defaults and limits
    // ************************************************************
    localparam logic [SET_W-1:0]        RATIO_DEF = 16'h0002;
    localparam logic [SET_W-1:0]        RATIO_MIN = 16'h0001;
    localparam logic [SET_W-1:0]        HIGH_DEF  = 16'h0001;
    localparam logic [SET_W-1:0]        HIGH_MIN  = 16'h0001;
    localparam logic signed [SET_W-1:0] START_DEF = 16'sh0000;

    // ************************************************************
    // Counter constants
    // ************************************************************
    localparam logic signed [CNT_W-1:0] CNT_RISE = 18'sh0_0001;
    localparam logic signed [CNT_W-1:0] CNT_STEP = 18'sh0_0001;
    localparam logic [SET_W-1:0]        EDGE_ONE = 16'h0001;

    // ************************************************************
    // States
    // ************************************************************
    typedef enum logic [1:0] {
        FDV_LOAD = 2'b01,
        FDV_RUN  = 2'b10
    } fdv_state_t;

endpackage : fdv_pkg

/* rtl/fdv_edge.sv */
/*
 * Rising-edge finder for the divider input.
 * Assumes the input is already synchronous to core_clk_i.
 */
module fdv_edge (
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    input  wire logic sig_i,
    output logic      rise_o
);

    logic last;
    logic next_last;

    always_comb begin
        next_last = sig_i;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last <= 1'b0;
        end else begin
            last <= next_last;
        end
    end

    // A falling edge yields no pulse.
    assign rise_o = sig_i & ~last;

endmodule // fdv_edge

/* rtl/fdv_divider.sv */
/*
 * Frequency divider with programmable ratio, output-high length and
 * counter start value.
 * Assumes freq_in_i and all settings are synchronous to core_clk_i and that
 * the settings are held steady while the divider runs.
 */
module fdv_divider (
    input  wire logic                            core_clk_i,
    input  wire logic                            nrst_i,
    input  wire logic                            freq_in_i,
    input  wire logic [fdv_pkg::SET_W-1:0]       div_ratio_i,
    input  wire logic [fdv_pkg::SET_W-1:0]       high_len_i,
    input  wire logic signed [fdv_pkg::SET_W-1:0] start_val_i,
    input  wire logic                            restart_i,
    output logic                                 freq_out_o,
    output logic                                 started_o,
    output logic [fdv_pkg::SET_W-1:0]            edge_cnt_o
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // A setting below its floor is taken at its floor.
    function automatic logic [fdv_pkg::SET_W-1:0] clamp_min(
        input logic [fdv_pkg::SET_W-1:0] val,
        input logic [fdv_pkg::SET_W-1:0] lim
    );
        clamp_min = (val < lim) ? lim : val;
    endfunction

    function automatic logic signed [fdv_pkg::CNT_W-1:0] widen(
        input logic [fdv_pkg::SET_W-1:0] val
    );
        widen = $signed({{(fdv_pkg::CNT_W - fdv_pkg::SET_W){1'b0}}, val});
    endfunction

    function automatic logic signed [fdv_pkg::CNT_W-1:0] sext_start(
        input logic signed [fdv_pkg::SET_W-1:0] val
    );
        sext_start = $signed({{(fdv_pkg::CNT_W - fdv_pkg::SET_W){val[fdv_pkg::SET_W-1]}}, val});
    endfunction

    // Reaching 1 plus the ratio folds back to the rising point; a start value
    // above the ratio folds there on its first step as well.
    function automatic logic signed [fdv_pkg::CNT_W-1:0] advance(
        input logic signed [fdv_pkg::CNT_W-1:0] cnt,
        input logic signed [fdv_pkg::CNT_W-1:0] wrap
    );
        logic signed [fdv_pkg::CNT_W-1:0] step;
        step    = cnt + fdv_pkg::CNT_STEP;
        advance = (step >= wrap) ? fdv_pkg::CNT_RISE : step;
    endfunction

    function automatic logic at_rise(
        input logic signed [fdv_pkg::CNT_W-1:0] cnt
    );
        at_rise = (cnt == fdv_pkg::CNT_RISE);
    endfunction

    function automatic logic in_window(
        input logic signed [fdv_pkg::CNT_W-1:0] cnt,
        input logic signed [fdv_pkg::CNT_W-1:0] hi_end
    );
        in_window = (cnt >= fdv_pkg::CNT_RISE) && (cnt <= hi_end);
    endfunction

    // ************************************************************
    // Input edges
    // ************************************************************
    logic in_rise;

    fdv_edge u_edge (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .sig_i      (freq_in_i),
        .rise_o     (in_rise)
    );

    // ************************************************************
    // Effective settings
    // ************************************************************
    logic [fdv_pkg::SET_W-1:0]        ratio_eff;
    logic [fdv_pkg::SET_W-1:0]        high_eff;
    logic signed [fdv_pkg::CNT_W-1:0] wrap_point;
    logic signed [fdv_pkg::CNT_W-1:0] high_end;

    always_comb begin
        ratio_eff  = clamp_min(div_ratio_i, fdv_pkg::RATIO_MIN);
        high_eff   = clamp_min(high_len_i, fdv_pkg::HIGH_MIN);
        wrap_point = fdv_pkg::CNT_RISE + widen(ratio_eff);
        high_end   = widen(high_eff);
    end

    // ************************************************************
    // Counter, output and state
    // ************************************************************
    fdv_pkg::fdv_state_t              state;
    fdv_pkg::fdv_state_t              next_state;
    logic signed [fdv_pkg::CNT_W-1:0] count;
    logic signed [fdv_pkg::CNT_W-1:0] next_count;
    logic                             out_q;
    logic                             next_out;
    logic                             started;
    logic                             next_started;
    logic [fdv_pkg::SET_W-1:0]        edges;
    logic [fdv_pkg::SET_W-1:0]        next_edges;
    logic                             load_now;
    logic                             count_step;

    // The start value is sampled only in the load cycle, so a change to it
    // while running takes effect at the next restart.
    always_comb begin
        load_now   = (state == fdv_pkg::FDV_LOAD);
        count_step = (state == fdv_pkg::FDV_RUN) && !restart_i && in_rise;
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            fdv_pkg::FDV_LOAD: begin
                next_state = fdv_pkg::FDV_RUN;
            end
            fdv_pkg::FDV_RUN: begin
                if (restart_i) begin
                    next_state = fdv_pkg::FDV_LOAD;
                end
            end
            default: begin
                next_state = fdv_pkg::FDV_LOAD;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= fdv_pkg::FDV_LOAD;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_comb begin
        next_count = count;
        if (load_now) begin
            next_count = sext_start(start_val_i);
        end else if (count_step) begin
            next_count = advance(count, wrap_point);
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // ************************************************************
    // Flags and output
    // ************************************************************
    // Started marks the first arrival at the rising point since the load.
    always_comb begin
        next_started = started;
        if (load_now) begin
            next_started = 1'b0;
        end else if (count_step && at_rise(next_count)) begin
            next_started = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            started <= 1'b0;
        end else begin
            started <= next_started;
        end
    end

    // Gating by the started flag keeps a positive start value that lies inside
    // the high window from raising the output before the first rising point.
    always_comb begin
        next_out = out_q;
        if (load_now) begin
            next_out = 1'b0;
        end else if (count_step) begin
            next_out = next_started && in_window(next_count, high_end);
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_q <= 1'b0;
        end else begin
            out_q <= next_out;
        end
    end

    // The tally wraps silently once it passes the widest setting value.
    always_comb begin
        next_edges = edges;
        if (load_now) begin
            next_edges = '0;
        end else if (count_step) begin
            next_edges = edges + fdv_pkg::EDGE_ONE;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edges <= '0;
        end else begin
            edges <= next_edges;
        end
    end

    assign freq_out_o = out_q;
    assign started_o  = started;
    assign edge_cnt_o = edges;

endmodule // fdv_divider

/* verification/fdv_monitor.sv */
/* Port checker for fdv_divider.
   Assumes the settings stay steady between restarts. */
module fdv_monitor #(parameter int W = fdv_pkg::SET_W) (
    input wire logic                      core_clk_i,
    input wire logic                      nrst_i,
    input wire logic                      freq_in_i,
    input wire logic [W-1:0]              div_ratio_i,
    input wire logic [W-1:0]              high_len_i,
    input wire logic signed [W-1:0]       start_val_i,
    input wire logic                      restart_i,
    input wire logic                      freq_out_o,
    input wire logic                      started_o,
    input wire logic [W-1:0]              edge_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic prev, next_prev, loaded, next_loaded, rise, run;
    int   n_e, r_e, h_e;
    // The first edge after reset or restart only loads, so it never counts.
    always_comb begin
        next_prev   = freq_in_i;
        next_loaded = !loaded || !restart_i;
        rise        = freq_in_i && !prev;
        run         = loaded && !restart_i;
        n_e         = int'(edge_cnt_o) + int'(start_val_i) - 1;
        r_e         = (div_ratio_i == '0) ? 1 : int'(div_ratio_i);
        h_e         = (high_len_i == '0) ? 1 : int'(high_len_i);
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev   <= 1'h0;
            loaded <= 1'h0;
        end else begin
            prev   <= next_prev;
            loaded <= next_loaded;
        end
    end
    property p_fall; run && !rise |=> $stable(freq_out_o) && $stable(edge_cnt_o); endproperty
    property p_cnt; run && rise |=> edge_cnt_o == W'($past(edge_cnt_o) + 1'h1); endproperty
    property p_load; !loaded |=> edge_cnt_o == '0 && !started_o; endproperty
    property p_first; run && rise && edge_cnt_o == '0 && start_val_i == '0 |=> freq_out_o && started_o; endproperty
    property p_late;
        run && (start_val_i == -20 || (start_val_i == 5 && div_ratio_i == 10))
        |-> started_o == (edge_cnt_o >= ((start_val_i == 5) ? 6 : 21));
    endproperty
    property p_rise; $rose(started_o) |-> freq_out_o; endproperty
    property p_pre; run && !started_o |-> !freq_out_o; endproperty
    property p_shape; run && started_o && start_val_i <= 0 |-> freq_out_o == ((n_e % r_e) < h_e); endproperty
    a_fall: assert property (p_fall) else $error("output moved without input rise");
    a_cnt: assert property (p_cnt) else $error("edge count did not step");
    a_load: assert property (p_load) else $error("load did not clear");
    a_first: assert property (p_first) else $error("no high after first edge");
    a_late: assert property (p_late) else $error("first high at wrong edge");
    a_rise: assert property (p_rise) else $error("counter at one but output low");
    a_pre: assert property (p_pre) else $error("output high before first rise");
    a_shape: assert property (p_shape) else $error("output duty or period wrong");
    c_run: cover property (run && rise && started_o);
    c_neg: cover property (start_val_i == -20 && $rose(started_o));
    c_fell: cover property (run && $fell(freq_out_o));
endmodule // fdv_monitor
bind fdv_divider fdv_monitor i_mon (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .freq_in_i(freq_in_i),
    .div_ratio_i(div_ratio_i), .high_len_i(high_len_i), .start_val_i(start_val_i), .restart_i(restart_i),
    .freq_out_o(freq_out_o), .started_o(started_o), .edge_cnt_o(edge_cnt_o));

/* verification/tb.sv */
/* Self-checking bench for fdv_divider with a reference counter model.
   Assumes one clock; inputs change on falling edges. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, nrst = 0, fin = 0, rst_q = 0, fout, strt;
    logic [15:0] ratio, high, cnt;
    logic signed [15:0] start;
    int error_cnt = 0, comparisons = 0, seed = 10, c, n, st, re, he, k, i;
    always #4 clk = ~clk;
    fdv_divider i_fdv_divider (.core_clk_i(clk), .nrst_i(nrst), .freq_in_i(fin), .div_ratio_i(ratio),
        .high_len_i(high), .start_val_i(start), .restart_i(rst_q), .freq_out_o(fout), .started_o(strt),
        .edge_cnt_o(cnt));
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic int step_model(input int cc, input int r);
        return (cc + 1 >= 1 + r) ? 1 : cc + 1;
    endfunction
    // The output may only be high once the rising point has been reached.
    function automatic logic [15:0] high_model(input int cc, input int h, input int s);
        return 16'(s != 0 && cc >= 1 && cc <= h);
    endfunction
    task rst_seq;
        @(negedge clk) nrst = 0;
        repeat (5) @(negedge clk);
        chk("reset_out", 16'(fout), 16'h0000);
        chk("reset_started", 16'(strt), 16'h0000);
        chk("reset_cnt", cnt, 16'h0000);
        nrst = 1;
    endtask
    task load(input int r, input int h, input int s);
        @(negedge clk) {ratio, high, start, rst_q} = {r[15:0], h[15:0], s[15:0], 1'b1};
        @(negedge clk) rst_q = 0;
        @(negedge clk);
        {c, n, st, re, he} = {s, 0, 0, (r == 0) ? 1 : r, (h == 0) ? 1 : h};
    endtask
    // Holding the input high over several clocks checks that only the rise counts.
    task pulse(input int hi);
        @(negedge clk) fin = 1;
        repeat (hi) @(negedge clk);
        fin = 0;
        c = step_model(c, re);
        st = st | (c == 1);
        n++;
        chk("freq_out", fout, high_model(c, he, st));
        chk("started", strt, 16'(st));
        chk("edge_cnt", cnt, 16'(n));
    endtask
    task results;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        results;
    end
    initial begin
        {ratio, high, start} = {fdv_pkg::RATIO_DEF, fdv_pkg::HIGH_DEF, fdv_pkg::START_DEF};
        rst_seq;
        load(2, 1, 0);
        for (i = 0; i < 6; i++) pulse(1);
        $display("test ratio 2 done");
        load(0, 0, 0);
        for (i = 0; i < 4; i++) pulse(2);
        $display("test zero settings done");
        load(10, 1, 5);
        for (i = 0; i < 14; i++) pulse(1);
        load(10, 8, 5);
        for (i = 0; i < 14; i++) pulse(1);
        $display("test start 5 done");
        load(3, 2, -20);
        for (i = 0; i < 26; i++) pulse(1);
        $display("test start -20 done");
        load(3, 1, 7);
        for (i = 0; i < 8; i++) pulse(1);
        rst_seq;
        $display("test fold and mid-run reset done");
        $display("corner tests done");
        for (k = 0; k < 8; k++) begin
            load(($random(seed) & 15) + 1, ($random(seed) & 15) + 1, -($random(seed) & 31));
            for (i = 0; i < 3 * re + 32; i++) pulse(1 + ($random(seed) & 3));
        end
        $display("random tests done");
        results;
    end
endmodule // tb
